// ==== verilog/flra_top.sv ====
// flow result averaging: sampling, averaging, flags and readout handshake
`timescale 1ns/1ps
module flra_top #(
   parameter int SAMPLE_CYC = flra_pkg::SAMPLE_CYC,
   parameter int TEMP_CYC = flra_pkg::TEMP_CYC,
   parameter int INIT_CYC = flra_pkg::INIT_CYC
) (
   // system clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // link clock
   input wire logic link_clk,
   // link commands, one-cycle pulses on link_clk
   input wire logic link_start,
   input wire logic link_stop,
   input wire logic link_read_req,
   input wire logic link_flow_taken,
   input wire logic link_flags_taken,
   // link answers on link_clk
   output logic link_read_ack,
   output logic link_read_nack,
   output logic [15:0] link_flow_word,
   output logic [7:0] link_flow_crc,
   output logic [15:0] link_temp_word,
   output logic [7:0] link_temp_crc,
   output logic [15:0] link_flag_word,
   output logic [7:0] link_flag_crc,
   // sensor front end on sys_clk
   input wire logic signed [15:0] flow_raw,
   input wire logic [15:0] temp_raw,
   input wire logic air_detect,
   input wire logic flow_over_limit,
   // control and status on sys_clk
   input wire logic irq_enable,
   output logic heater_on,
   output logic bus_ready,
   output logic smoothing_active,
   output logic new_data_request_n
);

   localparam int TW = flra_pkg::TIMER_W;
   localparam int AW = flra_pkg::ACC_W;
   localparam int SW = flra_pkg::SM_W;
   localparam int CW = flra_pkg::CNT_W;
   localparam int DW = flra_pkg::WORD_W;

   // whole sys_clk state
   typedef struct packed {
      flra_pkg::flra_meas_e state;
      logic [TW-1:0] timer;            // init delay, then sample period
      logic [TW-1:0] ttimer;           // temperature period
      logic signed [AW-1:0] acc;       // sum of samples in window
      logic [CW-1:0] count;            // samples in window
      logic signed [SW-1:0] smooth;    // smoothed value, fixed point
      logic smoothing;                 // window past 100 ms
      logic signed [DW-1:0] flow_out;  // current averaged flow
      logic [DW-1:0] temp;             // latest temperature
      logic avail;                     // first result exists
      logic new_data;                  // result not yet read
      logic air_flag;
      logic high_flag;
      logic snap_valid;
      logic [DW-1:0] snap_flow;
      logic [DW-1:0] snap_temp;
      logic [DW-1:0] snap_flags;
      logic [7:0] snap_fcrc;
      logic [7:0] snap_tcrc;
      logic [7:0] snap_gcrc;
      logic ready;
      logic heater;
      logic irq_n;
   } flra_sys_s;

   // whole link_clk state
   typedef struct packed {
      logic ack;
      logic nack;
      logic [DW-1:0] flow;
      logic [7:0] fcrc;
      logic [DW-1:0] temp;
      logic [7:0] tcrc;
      logic [DW-1:0] flags;
      logic [7:0] gcrc;
   } flra_link_s;

   flra_sys_s sr, sn;
   flra_link_s lr, ln;

   // reset carried into the link domain; stage 0 only feeds stage 1
   logic [1:0] lrst_sync_reg;
   logic link_rst;

   // crossed events
   logic [flra_pkg::EVT_W-1:0] link_evt;
   logic [flra_pkg::EVT_W-1:0] sys_evt;
   logic done_evt;

   // decoded sys events
   logic start_evt, stop_evt, read_evt, flow_taken_evt, flags_taken_evt;

   // combinational helpers of the sys process
   logic sample_tick, temp_tick, restart, measuring;
   logic signed [AW-1:0] acc_base, acc_sum, mean;
   logic [CW-1:0] cnt_base, cnt_sum;
   logic smooth_base;
   logic signed [SW-1:0] seed, delta;
   logic [DW-1:0] flags_w;

   // link reset synchroniser, no reset of its own
   always_ff @(posedge link_clk) begin
      lrst_sync_reg <= {lrst_sync_reg[0], reset};
   end
   assign link_rst = lrst_sync_reg[1];

   // link commands into sys_clk
   assign link_evt = {link_flags_taken, link_flow_taken, link_read_req, link_stop, link_start};

   flra_evt_sync #(.W(flra_pkg::EVT_W)) u_cmd_sync (
      .src_clk(link_clk),
      .src_reset(link_rst),
      .src_pulse(link_evt),
      .dst_clk(sys_clk),
      .dst_reset(reset),
      .dst_pulse(sys_evt)
   );

   // snapshot ready back into link_clk; snapshot words stay put meanwhile
   flra_evt_sync #(.W(1)) u_done_sync (
      .src_clk(sys_clk),
      .src_reset(reset),
      .src_pulse(read_evt),
      .dst_clk(link_clk),
      .dst_reset(link_rst),
      .dst_pulse(done_evt)
   );

   assign start_evt = sys_evt[flra_pkg::EV_START];
   assign stop_evt = sys_evt[flra_pkg::EV_STOP];
   assign read_evt = sys_evt[flra_pkg::EV_READ];
   assign flow_taken_evt = sys_evt[flra_pkg::EV_FLOW];
   assign flags_taken_evt = sys_evt[flra_pkg::EV_FLAGS];

   // sys next state: sequencer, averaging, flags, snapshot
   always_comb begin
      sn = sr;
      sample_tick = 1'b0;
      temp_tick = 1'b0;
      acc_sum = '0;
      cnt_sum = '0;
      mean = '0;
      seed = '0;
      delta = '0;
      flags_w = '0;
      measuring = (sr.state != flra_pkg::FLRA_IDLE);
      // always answering one cycle after reset, far inside 25 ms
      sn.ready = 1'b1;
      unique case (sr.state)
         flra_pkg::FLRA_IDLE: begin
            // nothing runs until a start command arrives
            if (start_evt) begin
               sn.state = flra_pkg::FLRA_INIT;
               sn.timer = '0;
            end
         end
         flra_pkg::FLRA_INIT: begin
            // first result only after the init delay
            sn.timer = sr.timer + TW'(1);
            if (sr.timer == TW'(INIT_CYC - 1)) begin
               sn.state = flra_pkg::FLRA_RUN;
               sn.timer = '0;
               sn.ttimer = '0;
               sn.avail = 1'b1;
               sample_tick = 1'b1;
               temp_tick = 1'b1;
            end
         end
         flra_pkg::FLRA_RUN: begin
            // flow every sample period, temperature on its own period
            sn.timer = sr.timer + TW'(1);
            sn.ttimer = sr.ttimer + TW'(1);
            if (sr.timer == TW'(SAMPLE_CYC - 1)) begin
               sn.timer = '0;
               sample_tick = 1'b1;
            end
            if (sr.ttimer == TW'(TEMP_CYC - 1)) begin
               sn.ttimer = '0;
               temp_tick = 1'b1;
            end
         end
      endcase
      // stop drops back to idle; a start while running is ignored
      if (stop_evt && measuring) begin
         sn.state = flra_pkg::FLRA_IDLE;
         sn.avail = 1'b0;
         sample_tick = 1'b0;
         temp_tick = 1'b0;
      end
      // flow readout or fresh start opens a new window
      restart = flow_taken_evt || (start_evt && !measuring);
      acc_base = sr.acc;
      cnt_base = sr.count;
      smooth_base = sr.smoothing;
      if (restart) begin
         acc_base = '0;
         cnt_base = '0;
         smooth_base = 1'b0;
      end
      if (flow_taken_evt) begin
         sn.new_data = 1'b0;
      end
      sn.acc = acc_base;
      sn.count = cnt_base;
      sn.smoothing = smooth_base;
      // a sample landing with the readout belongs to the new window
      if (sample_tick) begin
         sn.new_data = 1'b1;
         if (!smooth_base && cnt_base != CW'(flra_pkg::WIN_SAMPLES)) begin
            // plain mean of everything since the readout
            acc_sum = acc_base + AW'(flow_raw);
            cnt_sum = cnt_base + CW'(1);
            mean = acc_sum / $signed(AW'(cnt_sum));
            sn.acc = acc_sum;
            sn.count = cnt_sum;
            sn.flow_out = mean[DW-1:0];
         end else begin
            // first smoothed step is seeded with the 100 ms mean
            seed = smooth_base ? sr.smooth : (SW'(sr.flow_out) <<< flra_pkg::FRAC_BITS);
            delta = (SW'(flow_raw) <<< flra_pkg::FRAC_BITS) - seed;
            sn.smooth = seed + delta / flra_pkg::ALPHA_DIV;
            sn.smoothing = 1'b1;
            sn.flow_out = sn.smooth[flra_pkg::FRAC_BITS +: DW];
         end
      end
      // temperature is a plain latch of the newest sample
      if (temp_tick) begin
         sn.temp = temp_raw;
      end
      // sticky failure flags: clear what was reported, new event wins
      if (flags_taken_evt) begin
         sn.air_flag = sr.air_flag & ~sr.snap_flags[flra_pkg::FLAG_AIR];
         sn.high_flag = sr.high_flag & ~sr.snap_flags[flra_pkg::FLAG_HIGH];
      end
      if (air_detect && measuring) begin
         sn.air_flag = 1'b1;
      end
      if (flow_over_limit && measuring) begin
         sn.high_flag = 1'b1;
      end
      // read header: freeze a snapshot for the link to pick up
      flags_w[flra_pkg::FLAG_AIR] = sr.air_flag;
      flags_w[flra_pkg::FLAG_HIGH] = sr.high_flag;
      flags_w[flra_pkg::FLAG_SMOOTH] = sr.smoothing;
      if (read_evt) begin
         sn.snap_valid = sr.avail;
         sn.snap_flow = sr.flow_out;
         sn.snap_temp = sr.temp;
         sn.snap_flags = flags_w;
         sn.snap_fcrc = flra_pkg::flra_crc8(sr.flow_out);
         sn.snap_tcrc = flra_pkg::flra_crc8(sr.temp);
         sn.snap_gcrc = flra_pkg::flra_crc8(flags_w);
      end
      // pin stays high unless enabled and a result is pending
      sn.irq_n = ~(irq_enable & sn.new_data);
      sn.heater = (sn.state != flra_pkg::FLRA_IDLE);
   end

   // sys register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sr <= '{state: flra_pkg::FLRA_IDLE, irq_n: 1'b1, default: '0};
      end else begin
         sr <= sn;
      end
   end

   // link next state: answer each read header with ack or nack
   always_comb begin
      ln = lr;
      ln.ack = 1'b0;
      ln.nack = 1'b0;
      if (done_evt) begin
         ln.ack = sr.snap_valid;
         ln.nack = !sr.snap_valid;
         // snapshot words are quiet here: written at the toggle's sys edge, seen two link edges later
         if (sr.snap_valid) begin
            ln.flow = sr.snap_flow;
            ln.fcrc = sr.snap_fcrc;
            ln.temp = sr.snap_temp;
            ln.tcrc = sr.snap_tcrc;
            ln.flags = sr.snap_flags;
            ln.gcrc = sr.snap_gcrc;
         end
      end
   end

   // link register
   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         lr <= '0;
      end else begin
         lr <= ln;
      end
   end

   // outputs straight from the state registers
   assign link_read_ack = lr.ack;
   assign link_read_nack = lr.nack;
   assign link_flow_word = lr.flow;
   assign link_flow_crc = lr.fcrc;
   assign link_temp_word = lr.temp;
   assign link_temp_crc = lr.tcrc;
   assign link_flag_word = lr.flags;
   assign link_flag_crc = lr.gcrc;
   assign heater_on = sr.heater;
   assign bus_ready = sr.ready;
   assign smoothing_active = sr.smoothing;
   assign new_data_request_n = sr.irq_n;

   // idle without a start keeps the heater off
   heater_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      (sr.state == flra_pkg::FLRA_IDLE && !start_evt) |=> !heater_on)
      else $error("heater on while idle");
   // result appears only at the end of the init delay
   init_delay_a: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(sr.avail) |-> ($past(sr.state) == flra_pkg::FLRA_INIT && $past(sr.timer) == TW'(INIT_CYC - 1)))
      else $error("result before init delay ended");
   // a sample tick while running restarts the period counter
   sample_period_a: assert property (@(posedge sys_clk) disable iff (reset)
      (sample_tick && sr.state == flra_pkg::FLRA_RUN && !stop_evt) |=> (sr.timer == '0 && sr.new_data))
      else $error("sample period not restarted");
   // smoothing starts only after a full 100 ms window
   smooth_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(sr.smoothing) |-> $past(sr.count) == CW'(flra_pkg::WIN_SAMPLES))
      else $error("smoothing entered early");
   // flow readout without a sample empties the window
   window_restart_a: assert property (@(posedge sys_clk) disable iff (reset)
      (flow_taken_evt && !sample_tick) |=> (sr.count == '0 && !sr.smoothing && new_data_request_n))
      else $error("window not restarted by readout");
   // reported flag word mirrors the smoothing state
   smooth_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
      read_evt |=> sr.snap_flags[flra_pkg::FLAG_SMOOTH] == $past(sr.smoothing))
      else $error("smoothing bit wrong in snapshot");
   // air event latches even against a clear
   air_sticky_a: assert property (@(posedge sys_clk) disable iff (reset)
      (air_detect && sr.state != flra_pkg::FLRA_IDLE) |=> sr.air_flag)
      else $error("air flag not latched");
   // high flow flag holds until the flag word is taken
   high_sticky_a: assert property (@(posedge sys_clk) disable iff (reset)
      (sr.high_flag && !flags_taken_evt) |=> sr.high_flag)
      else $error("high flow flag dropped early");
   // temperature changes only on its tick
   temp_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      !temp_tick |=> sr.temp == $past(sr.temp))
      else $error("temperature changed between samples");
   // disabled pin stays high
   irq_off_a: assert property (@(posedge sys_clk) disable iff (reset)
      !irq_enable |=> new_data_request_n)
      else $error("new data pin active while disabled");
   // no ack before the first result; sys reset masks the link side until its synced copy fills
   nack_early_a: assert property (@(posedge link_clk) disable iff (reset || link_rst)
      link_read_ack |-> sr.snap_valid)
      else $error("read acknowledged without data");
   // reserved flag bits never set
   reserved_zero_a: assert property (@(posedge link_clk) disable iff (reset || link_rst)
      (link_flag_word & ~((DW'(1) << flra_pkg::FLAG_AIR) | (DW'(1) << flra_pkg::FLAG_HIGH)
      | (DW'(1) << flra_pkg::FLAG_SMOOTH))) == '0)
      else $error("reserved flag bit set");

endmodule : flra_top

// ==== verilog/flra_pkg.sv ====
// flow result averaging: shared timing, layout, crc and state definitions
package flra_pkg;

   // clock rate and documented times in microseconds
   localparam int CLK_MHZ = 20;
   localparam int SAMPLE_US = 500;
   localparam int WINDOW_US = 100000;
   localparam int TEMP_US = 12000;
   localparam int INIT_US = 12000;

   // derived cycle counts and window length in samples
   localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
   localparam int TEMP_CYC = TEMP_US * CLK_MHZ;
   localparam int INIT_CYC = INIT_US * CLK_MHZ;
   localparam int WIN_SAMPLES = WINDOW_US / SAMPLE_US;

   // smoothing: alpha 0.0125 is exactly one part in 80
   localparam int ALPHA_DIV = 80;
   localparam int FRAC_BITS = 8;

   // widths
   localparam int WORD_W = 16;
   localparam int CRC_W = 8;
   localparam int CNT_W = 8;
   localparam int ACC_W = 24;
   localparam int SM_W = 32;
   localparam int TIMER_W = 20;
   localparam int EVT_W = 5;

   // signaling flag word bit positions
   localparam int FLAG_AIR = 0;
   localparam int FLAG_HIGH = 1;
   localparam int FLAG_SMOOTH = 5;

   // link event vector positions
   localparam int EV_START = 0;
   localparam int EV_STOP = 1;
   localparam int EV_READ = 2;
   localparam int EV_FLOW = 3;
   localparam int EV_FLAGS = 4;

   // checksum polynomial and seed
   localparam logic [7:0] CRC_POLY = 8'h31;
   localparam logic [7:0] CRC_INIT = 8'hff;

   // measurement sequencer states
   typedef enum logic [1:0] {FLRA_IDLE, FLRA_INIT, FLRA_RUN} flra_meas_e;

   // msb-first crc over one data word
   function automatic logic [7:0] flra_crc8(input logic [15:0] data);
      logic [7:0] crc;
      crc = CRC_INIT;
      for (int i = WORD_W - 1; i >= 0; i--) begin
         if (crc[7] ^ data[i]) begin
            crc = {crc[6:0], 1'b0} ^ CRC_POLY;
         end else begin
            crc = {crc[6:0], 1'b0};
         end
      end
      return crc;
   endfunction : flra_crc8

endpackage : flra_pkg

// ==== verilog/flra_evt_sync.sv ====
// flow result averaging: toggle-based event crossing between two clocks
`timescale 1ns/1ps
module flra_evt_sync #(
   parameter int W = 1
) (
   // source side
   input wire logic src_clk,
   input wire logic src_reset,
   input wire logic [W-1:0] src_pulse,
   // destination side
   input wire logic dst_clk,
   input wire logic dst_reset,
   output logic [W-1:0] dst_pulse
);

   // source state: one toggle per event lane
   typedef struct packed {
      logic [W-1:0] tog;
   } flra_src_s;

   // destination state: two sync stages plus edge history
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } flra_dst_s;

   flra_src_s src_reg, src_next;
   flra_dst_s dst_reg, dst_next;

   // each pulse flips its lane; two pulses with no dst edge between them cancel out
   always_comb begin
      src_next = src_reg;
      src_next.tog = src_reg.tog ^ src_pulse;
   end

   always_ff @(posedge src_clk) begin
      if (src_reset) begin
         src_reg <= '0;
      end else begin
         src_reg <= src_next;
      end
   end

   // s1 feeds s2 only; the edge detector looks at s2 and s3
   always_comb begin
      dst_next = dst_reg;
      dst_next.s1 = src_reg.tog;
      dst_next.s2 = dst_reg.s1;
      dst_next.s3 = dst_reg.s2;
   end

   always_ff @(posedge dst_clk) begin
      if (dst_reset) begin
         dst_reg <= '0;
      end else begin
         dst_reg <= dst_next;
      end
   end

   // one dst cycle per source event
   assign dst_pulse = dst_reg.s2 ^ dst_reg.s3;

endmodule : flra_evt_sync

// ==== sim/flra_host_model.sv ====
// host-side model: issues link commands and collects read answers
`timescale 1ns/1ps
module flra_host_model (
   // link clock
   input wire logic link_clk,
   // commands to the device
   output logic link_start,
   output logic link_stop,
   output logic link_read_req,
   output logic link_flow_taken,
   output logic link_flags_taken,
   // answers from the device
   input wire logic link_read_ack,
   input wire logic link_read_nack
);
   // one bit per command, in the package's event order
   logic [4:0] cmd;

   assign link_start = cmd[0];
   assign link_stop = cmd[1];
   assign link_read_req = cmd[2];
   assign link_flow_taken = cmd[3];
   assign link_flags_taken = cmd[4];

   // quiet until the bench asks for something
   initial begin
      cmd = 5'h00;
   end

   // one-cycle pulse, then a gap so same-kind pulses never cancel
   task automatic send(input int k);
      @(posedge link_clk);
      cmd[k] <= 1'h1;
      @(posedge link_clk);
      cmd[k] <= 1'h0;
      repeat (4) @(posedge link_clk);
   endtask : send

   // read header, then wait a bounded time for ack or nack
   task automatic read(output logic ok, output logic refused);
      int n;
      ok = 1'h0;
      refused = 1'h0;
      @(posedge link_clk);
      cmd[2] <= 1'h1;
      @(posedge link_clk);
      cmd[2] <= 1'h0;
      n = 0;
      while (link_read_ack !== 1'h1 && link_read_nack !== 1'h1 && n < 20) begin
         @(posedge link_clk);
         n++;
      end
      ok = (link_read_ack === 1'h1);
      refused = (link_read_nack === 1'h1);
      repeat (4) @(posedge link_clk);
   endtask : read
endmodule : flra_host_model

// ==== sim/flra_top_test.sv ====
// testbench: averaging, temperature, sticky flags, new-data pin and start-up
`timescale 1ns/1ps
module flra_top_test;
   // short counts keep the run brief; the window stays 200 samples
   localparam int SAMPLE = 50;
   localparam int TEMP = 400;
   localparam int INIT = 100;

   // clocks, reset and sensor inputs
   logic sys_clk, link_clk, reset;
   logic signed [15:0] flow_raw;
   logic [15:0] temp_raw;
   logic air_detect, flow_over_limit, irq_enable;
   // link wires between model and device
   logic l_start, l_stop, l_req, l_flow, l_flags, l_ack, l_nack;
   logic [15:0] link_flow_word, link_temp_word, link_flag_word;
   logic [7:0] link_flow_crc, link_temp_crc, link_flag_crc;
   // status outputs
   logic heater_on, bus_ready, smoothing_active, new_data_request_n;
   // bench bookkeeping
   int error_cnt, checks, seed, n;
   logic [15:0] v, t;

   flra_top #(.SAMPLE_CYC(SAMPLE), .TEMP_CYC(TEMP), .INIT_CYC(INIT)) u_dut (
      .sys_clk(sys_clk), .reset(reset), .link_clk(link_clk),
      .link_start(l_start), .link_stop(l_stop), .link_read_req(l_req),
      .link_flow_taken(l_flow), .link_flags_taken(l_flags),
      .link_read_ack(l_ack), .link_read_nack(l_nack),
      .link_flow_word(link_flow_word), .link_flow_crc(link_flow_crc),
      .link_temp_word(link_temp_word), .link_temp_crc(link_temp_crc),
      .link_flag_word(link_flag_word), .link_flag_crc(link_flag_crc),
      .flow_raw(flow_raw), .temp_raw(temp_raw), .air_detect(air_detect),
      .flow_over_limit(flow_over_limit), .irq_enable(irq_enable),
      .heater_on(heater_on), .bus_ready(bus_ready),
      .smoothing_active(smoothing_active), .new_data_request_n(new_data_request_n)
   );

   flra_host_model u_host (
      .link_clk(link_clk), .link_start(l_start), .link_stop(l_stop),
      .link_read_req(l_req), .link_flow_taken(l_flow), .link_flags_taken(l_flags),
      .link_read_ack(l_ack), .link_read_nack(l_nack)
   );

   // 50 ns system clock
   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end

   // 30 ns link clock, offset so the phases never line up
   initial begin
      link_clk = 1'h0;
      #7;
      forever #15 link_clk = ~link_clk;
   end

   // independent checksum, msb first
   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 15; i >= 0; i--) begin
         c = (c[7] ^ d[i]) ? ({c[6:0], 1'h0} ^ 8'h31) : {c[6:0], 1'h0};
      end
      return c;
   endfunction : crc8

   // word compare
   task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_word

   // single-bit compare
   task automatic chk_bit(input string name, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_bit

   // read through the model, resume on a falling edge
   task automatic rd(input logic exp_ok);
      logic ok, nk;
      u_host.read(ok, nk);
      @(negedge sys_clk);
      chk_bit("read answer", exp_ok, ok);
      chk_bit("read refused", ~exp_ok, nk);
   endtask : rd

   // all three checksums against the held words
   task automatic chk_crc;
      chk_word("flow crc", {8'h00, crc8(link_flow_word)}, {8'h00, link_flow_crc});
      chk_word("temp crc", {8'h00, crc8(link_temp_word)}, {8'h00, link_temp_crc});
      chk_word("flag crc", {8'h00, crc8(link_flag_word)}, {8'h00, link_flag_crc});
   endtask : chk_crc

   // finish the readout: restart window and clear reported flags
   task automatic take_all;
      u_host.send(3);
      u_host.send(4);
      @(negedge sys_clk);
   endtask : take_all

   // verdict, reached from the sequence or the watchdog
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   // hang guard, well beyond the expected 13k cycles
   initial begin
      repeat (40000) @(posedge sys_clk);
      error_cnt++;
      close_out();
   end

   // main sequence
   initial begin
      seed = 6327;
      error_cnt = 0;
      checks = 0;
      flow_raw = 16'h0000;
      temp_raw = 16'h0000;
      air_detect = 1'h0;
      flow_over_limit = 1'h0;
      irq_enable = 1'h0;
      reset = 1'h1;
      repeat (10) @(negedge sys_clk);
      reset = 1'h0;
      @(negedge sys_clk);
      chk_bit("bus ready", 1'h1, bus_ready);
      chk_bit("heater idle", 1'h0, heater_on);
      repeat (10) @(negedge sys_clk);
      rd(1'h0);
      t = 16'($random(seed));
      temp_raw = t;
      u_host.send(0);
      repeat (2) @(negedge sys_clk);
      chk_bit("heater on", 1'h1, heater_on);
      rd(1'h0);
      // flow compared only after the warm-up has passed
      repeat (INIT + TEMP + 100) @(negedge sys_clk);
      chk_bit("pin disabled", 1'h1, new_data_request_n);
      // random constant flow per window: the mean must equal it
      for (int i = 0; i < 4; i++) begin
         v = 16'($random(seed));
         t = 16'($random(seed));
         flow_raw = v;
         temp_raw = t;
         rd(1'h1);
         take_all();
         repeat (TEMP + SAMPLE) @(negedge sys_clk);
         rd(1'h1);
         chk_word("flow mean", v, link_flow_word);
         chk_word("temp latest", t, link_temp_word);
         chk_word("flags quiet", 16'h0000, link_flag_word);
         chk_crc();
         take_all();
      end
      // new-data pin: low on data, high on flow readout, low again next sample
      irq_enable = 1'h1;
      repeat (SAMPLE + 5) @(negedge sys_clk);
      chk_bit("pin pending", 1'h0, new_data_request_n);
      rd(1'h1);
      u_host.send(3);
      n = 0;
      while (new_data_request_n !== 1'h1 && n < 12) begin
         @(negedge sys_clk);
         n++;
      end
      chk_bit("pin cleared", 1'h1, new_data_request_n);
      n = 0;
      while (new_data_request_n !== 1'h0 && n < SAMPLE + 10) begin
         @(negedge sys_clk);
         n++;
      end
      chk_bit("pin next sample", 1'h0, new_data_request_n);
      take_all();
      // one-cycle events must stick until their readout
      for (int k = 0; k < 2; k++) begin
         air_detect = (k == 0);
         flow_over_limit = (k == 1);
         @(negedge sys_clk);
         air_detect = 1'h0;
         flow_over_limit = 1'h0;
         repeat (SAMPLE) @(negedge sys_clk);
         rd(1'h1);
         chk_word("sticky flag", 16'h0001 << k, link_flag_word);
         chk_crc();
         take_all();
      end
      rd(1'h1);
      chk_word("flags cleared", 16'h0000, link_flag_word);
      take_all();
      // no readout past 200 samples: smoothing of a constant keeps it
      repeat (203 * SAMPLE) @(negedge sys_clk);
      chk_bit("smoothing on", 1'h1, smoothing_active);
      rd(1'h1);
      chk_word("smooth flag", 16'h0020, link_flag_word);
      chk_word("smooth flow", v, link_flow_word);
      take_all();
      repeat (5) @(negedge sys_clk);
      chk_bit("smoothing off", 1'h0, smoothing_active);
      u_host.send(1);
      repeat (10) @(negedge sys_clk);
      chk_bit("heater stopped", 1'h0, heater_on);
      close_out();
   end
endmodule : flra_top_test
